// ---- common/test_check_pkg.sv ----
// What this block does
// RULE_01 - Lane checker locks onto the incoming sequence with no link established.
// RULE_02 - Pattern select 0b00 PRBS7 (default), 0b01 PRBS15, 0b10 PRBS31.
// RULE_03 - Eight-bit lane enable arms checking per lane; several lanes at once.
// RULE_04 - Checker reset pulse clears pattern checker state and error counts.
// RULE_05 - 24-bit error threshold in three byte registers judges each lane.
// RULE_06 - Test starts only on a zero-to-one edge of the start bit.
// RULE_07 - Software runs the test about 500 ms, then clears start.
// RULE_08 - Transmitter sends the chosen sequence before the checker is started.
// RULE_09 - Per-lane result register: one is pass, zero is fail.
// RULE_10 - Three-bit selector picks the lane whose count shows.
// RULE_11 - Each lane counter is 24 bits and saturates at all ones.
// RULE_12 - Transmitter enables its short test pattern on a clean synchronized link first.
// RULE_13 - 16-bit expected sample held as high and low byte registers.
// RULE_14 - Four-bit select picks which of sixteen sample pattern words is compared.
// RULE_15 - Transport check runs only while its enable bit is one.
// RULE_16 - Transport check reset pulse clears the failure flag.
// RULE_17 - Selected sample compared every frame; any mismatch sets sticky fail at bit 0.
// RULE_18 - Software keeps transport check enabled about 1/(rate x error ratio).
// RULE_19 - Link carries one or two converters; the result names the converter and sample of the checked word.
// RULE_20 - Two-converter eight-lane: words map M0S0, M1S0, M0S1, M1S1 repeating.
// RULE_21 - Single-converter eight-lane: words map samples 0,2,1,3 repeating.
// RULE_22 - One-sample modes: even words converter 0, odd words converter 1.
// RULE_23 - Three-lane and six-lane links: transport check always reports failure.
// RULE_24 - Once locked, each bit differing from local sequence increments the counter.
package test_check_pkg;

    // ==========================================================
    // Register indices (byte address is index times four)
    localparam int ADDR_W = 14;
    localparam int IDX_LSB = 2;
    localparam logic [11:0] IDX_LANE_EN = 12'h315;
    localparam logic [11:0] IDX_PAT_CTRL = 12'h316;
    localparam logic [11:0] IDX_THR_LO = 12'h317;
    localparam logic [11:0] IDX_THR_MID = 12'h318;
    localparam logic [11:0] IDX_THR_HI = 12'h319;
    localparam logic [11:0] IDX_CNT_LO = 12'h31A;
    localparam logic [11:0] IDX_CNT_MID = 12'h31B;
    localparam logic [11:0] IDX_CNT_HI = 12'h31C;
    localparam logic [11:0] IDX_PASS = 12'h31D;
    localparam logic [11:0] IDX_TPL_CTRL = 12'h32C;
    localparam logic [11:0] IDX_EXP_LO = 12'h32D;
    localparam logic [11:0] IDX_EXP_HI = 12'h32E;
    localparam logic [11:0] IDX_TPL_RES = 12'h32F;

    // ==========================================================
    // Field positions and reset values
    localparam int PAT_RESET_BIT = 0;
    localparam int PAT_START_BIT = 1;
    localparam int PAT_SEL_LSB = 2;
    localparam int CNT_LANE_LSB = 4;
    localparam int TPL_EN_BIT = 0;
    localparam int TPL_RESET_BIT = 1;
    localparam int TPL_SEL_LSB = 4;
    localparam int RES_FAIL_BIT = 0;
    localparam int RES_CONV_BIT = 4;
    localparam int RES_SAMPLE_LSB = 5;
    localparam logic [7:0] REG8_RESET = 8'h00;
    localparam logic [23:0] THR_RESET = 24'h000000;
    localparam logic [15:0] EXP_RESET = 16'h0000;

    // ==========================================================
    // Pattern codes and feedback taps
    localparam logic [1:0] PAT_PRBS7 = 2'h0;
    localparam logic [1:0] PAT_PRBS15 = 2'h1;
    localparam logic [1:0] PAT_PRBS31 = 2'h2;
    localparam int TAP7_A = 6;
    localparam int TAP7_B = 5;
    localparam int TAP15_A = 14;
    localparam int TAP15_B = 13;
    localparam int TAP31_A = 30;
    localparam int TAP31_B = 27;
    localparam int PRBS_W = 31;
    localparam int ERR_W = 24;
    localparam int ERRS_W = 8;
    localparam int GOOD_W = 8;
    localparam int SAMPLE_W = 16;
    localparam int SAMPLE_WORDS = 16;
    localparam logic [3:0] LINK_L3 = 4'h3;
    localparam logic [3:0] LINK_L6 = 4'h6;
    localparam logic [3:0] LINK_L8 = 4'h8;

    typedef struct packed {
        logic valid;
        logic [SAMPLE_WORDS*SAMPLE_W-1:0] words;
    } tpl_frame_s;

    typedef struct packed {
        logic [PRBS_W-1:0] lfsr;
        logic [GOOD_W-1:0] good_cnt;
        logic locked;
        logic [ERR_W-1:0] err_cnt;
        logic pass;
    } lane_state_s;

    typedef struct packed {
        logic [PRBS_W-1:0] state;
        logic [ERRS_W-1:0] errs;
    } prbs_res_s;

endpackage

// ---- rtl/serdes_prbs_and_tpl_checker.sv ----
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/100ps
module serdes_prbs_and_tpl_checker
    import test_check_pkg::*;
#(
    parameter int LANES = 8,
    parameter int LANE_W = 8,
    parameter int LOCK_WORDS = 8
)
(
    input wire logic clk, // 200 MHz clock
    input wire logic reset, // Async reset, active high
    input wire logic [ADDR_W-1:0] avs_address, // Byte address
    input wire logic avs_read, // Read request
    input wire logic avs_write, // Write request
    input wire logic [3:0] avs_byteenable, // Byte lanes
    input wire logic [31:0] avs_writedata, // Write data
    output logic [31:0] avs_readdata, // Read data
    output logic avs_waitrequest, // Stall
    input wire logic [LANES*LANE_W-1:0] lane_data, // Received lane bits, MSB first
    input wire tpl_frame_s tpl_frame, // Deframed sample pattern words
    input wire logic [3:0] link_lane_count, // Configured lane count L
    input wire logic link_one_converter // Link carries a single converter
);

    // ==========================================================
    // Functions
    function automatic logic prbs_fb(input logic [PRBS_W-1:0] s, input logic [1:0] sel);
        logic f;
        unique case (sel)
            PAT_PRBS7: f = s[TAP7_A] ^ s[TAP7_B]; // see RULE_02
            PAT_PRBS15: f = s[TAP15_A] ^ s[TAP15_B];
            PAT_PRBS31: f = s[TAP31_A] ^ s[TAP31_B];
            default: f = s[TAP7_A] ^ s[TAP7_B];
        endcase
        return f;
    endfunction

    // While seeding, the history is fed from the line so lock needs no link state
    function automatic prbs_res_s prbs_word(input logic [PRBS_W-1:0] s,
                                            input logic [LANE_W-1:0] rx,
                                            input logic [1:0] sel,
                                            input logic seed);
        prbs_res_s r;
        logic e;
        r.state = s;
        r.errs = '0;
        for (int k = LANE_W - 1; k >= 0; k--)
        begin
            e = prbs_fb(r.state, sel);
            if (e != rx[k])
            begin
                r.errs = r.errs + 1'b1; // see RULE_24
            end
            r.state = {r.state[PRBS_W-2:0], seed ? rx[k] : e}; // see RULE_01
        end
        return r;
    endfunction

    function automatic logic [ERR_W-1:0] sat_add(input logic [ERR_W-1:0] c,
                                                 input logic [ERRS_W-1:0] d);
        logic [ERR_W:0] sum;
        sum = {1'b0, c} + {{(ERR_W+1-ERRS_W){1'b0}}, d};
        return sum[ERR_W] ? {ERR_W{1'b1}} : sum[ERR_W-1:0]; // see RULE_11
    endfunction

    // Sample index over converter ({sample, conv}) that a pattern word carries
    function automatic logic [2:0] sample_id(input logic [3:0] sel, input logic [3:0] lanes,
                                             input logic one_conv);
        logic [2:0] id;
        if (one_conv)
        begin
            id = {sel[0], sel[1], 1'b0}; // see RULE_21
        end
        else if (lanes == LINK_L8)
        begin
            id = {1'b0, sel[1], sel[0]}; // see RULE_20
        end
        else
        begin
            id = {2'b00, sel[0]}; // see RULE_22
        end
        return id;
    endfunction

    // ==========================================================
    // Register bus
    logic wait_reg, wait_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [7:0] lane_en_reg, lane_en_next;
    logic [7:0] pat_ctrl_reg, pat_ctrl_next;
    logic [ERR_W-1:0] thr_reg, thr_next;
    logic [7:0] tpl_ctrl_reg, tpl_ctrl_next;
    logic [SAMPLE_W-1:0] exp_reg, exp_next;
    logic [11:0] idx;
    logic wr_take;
    logic [7:0] wbyte;
    logic [ERR_W-1:0] sel_count;
    logic [LANES-1:0] pass_vec;
    logic [2:0] cnt_lane;
    logic tpl_fail_reg, tpl_fail_next;
    lane_state_s lane_q [LANES];
    lane_state_s lane_d [LANES];

    assign idx = avs_address[ADDR_W-1:IDX_LSB];
    assign wbyte = avs_writedata[7:0];
    assign cnt_lane = pat_ctrl_reg[CNT_LANE_LSB +: 3];
    // Writes land on the edge where waitrequest is seen low
    assign wr_take = avs_write && !wait_reg && avs_byteenable[0];

    always_comb
    begin
        sel_count = lane_q[0].err_cnt;
        pass_vec = '0;
        for (int i = 0; i < LANES; i++)
        begin
            pass_vec[i] = lane_q[i].pass; // see RULE_09
            if (cnt_lane == 3'(i))
            begin
                sel_count = lane_q[i].err_cnt; // see RULE_10
            end
        end
    end

    always_comb
    begin
        wait_next = 1'b1;
        rdata_next = rdata_reg;
        lane_en_next = lane_en_reg;
        pat_ctrl_next = pat_ctrl_reg;
        thr_next = thr_reg;
        tpl_ctrl_next = tpl_ctrl_reg;
        exp_next = exp_reg;
        if (wait_reg && (avs_read || avs_write))
        begin
            wait_next = 1'b0;
            rdata_next = '0;
            if (avs_read)
            begin
                unique case (idx)
                    IDX_LANE_EN: rdata_next[7:0] = lane_en_reg;
                    IDX_PAT_CTRL: rdata_next[7:0] = pat_ctrl_reg;
                    IDX_THR_LO: rdata_next[7:0] = thr_reg[7:0];
                    IDX_THR_MID: rdata_next[7:0] = thr_reg[15:8];
                    IDX_THR_HI: rdata_next[7:0] = thr_reg[23:16];
                    IDX_CNT_LO: rdata_next[7:0] = sel_count[7:0]; // see RULE_10
                    IDX_CNT_MID: rdata_next[7:0] = sel_count[15:8];
                    IDX_CNT_HI: rdata_next[7:0] = sel_count[23:16];
                    IDX_PASS: rdata_next[LANES-1:0] = pass_vec; // see RULE_09
                    IDX_TPL_CTRL: rdata_next[7:0] = tpl_ctrl_reg;
                    IDX_EXP_LO: rdata_next[7:0] = exp_reg[7:0];
                    IDX_EXP_HI: rdata_next[7:0] = exp_reg[15:8];
                    IDX_TPL_RES:
                    begin
                        rdata_next[RES_FAIL_BIT] = tpl_fail_reg; // see RULE_17
                        rdata_next[RES_CONV_BIT +: 3] = sample_id(
                            tpl_ctrl_reg[TPL_SEL_LSB +: 4], link_lane_count,
                            link_one_converter); // see RULE_19
                    end
                    default: rdata_next = '0;
                endcase
            end
        end
        if (wr_take)
        begin
            unique case (idx)
                IDX_LANE_EN: lane_en_next = wbyte; // see RULE_03
                IDX_PAT_CTRL: pat_ctrl_next = wbyte;
                IDX_THR_LO: thr_next[7:0] = wbyte; // see RULE_05
                IDX_THR_MID: thr_next[15:8] = wbyte;
                IDX_THR_HI: thr_next[23:16] = wbyte;
                IDX_TPL_CTRL: tpl_ctrl_next = wbyte;
                IDX_EXP_LO: exp_next[7:0] = wbyte; // see RULE_13
                IDX_EXP_HI: exp_next[15:8] = wbyte;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            wait_reg <= 1'b1;
            rdata_reg <= '0;
            lane_en_reg <= REG8_RESET;
            pat_ctrl_reg <= REG8_RESET;
            thr_reg <= THR_RESET;
            tpl_ctrl_reg <= REG8_RESET;
            exp_reg <= EXP_RESET;
        end
        else
        begin
            wait_reg <= wait_next;
            rdata_reg <= rdata_next;
            lane_en_reg <= lane_en_next;
            pat_ctrl_reg <= pat_ctrl_next;
            thr_reg <= thr_next;
            tpl_ctrl_reg <= tpl_ctrl_next;
            exp_reg <= exp_next;
        end
    end

    assign avs_waitrequest = wait_reg;
    assign avs_readdata = rdata_reg;

    // ==========================================================
    // Lane pattern checkers
    logic start_prev_reg, start_prev_next;
    logic running_reg, running_next;
    logic ck_reset;
    logic start_bit;
    logic [1:0] pat_sel;
    prbs_res_s res [LANES];

    assign ck_reset = pat_ctrl_reg[PAT_RESET_BIT];
    assign start_bit = pat_ctrl_reg[PAT_START_BIT];
    assign pat_sel = pat_ctrl_reg[PAT_SEL_LSB +: 2];

    always_comb
    begin
        start_prev_next = start_bit;
        running_next = running_reg;
        if (!start_bit)
        begin
            running_next = 1'b0; // see RULE_07
        end
        else if (!start_prev_reg)
        begin
            running_next = 1'b1; // see RULE_06
        end
    end

    always_comb
    begin
        for (int i = 0; i < LANES; i++)
        begin
            lane_d[i] = lane_q[i];
            res[i] = prbs_word(lane_q[i].lfsr, lane_data[i*LANE_W +: LANE_W], pat_sel,
                               !lane_q[i].locked);
            if (ck_reset)
            begin
                lane_d[i] = '0; // see RULE_04
            end
            else if (!lane_en_reg[i])
            begin
                lane_d[i].locked = 1'b0; // see RULE_03
                lane_d[i].good_cnt = '0;
            end
            else
            begin
                lane_d[i].lfsr = res[i].state;
                if (!lane_q[i].locked)
                begin
                    // Several clean words are needed so the history is full before lock
                    if (res[i].errs == '0)
                    begin
                        lane_d[i].good_cnt = lane_q[i].good_cnt + 1'b1;
                        if (lane_q[i].good_cnt == GOOD_W'(LOCK_WORDS - 1))
                        begin
                            lane_d[i].locked = 1'b1; // see RULE_01
                        end
                    end
                    else
                    begin
                        lane_d[i].good_cnt = '0;
                    end
                end
                else if (running_reg)
                begin
                    lane_d[i].err_cnt = sat_add(lane_q[i].err_cnt, res[i].errs); // see RULE_24
                end
            end
            lane_d[i].pass = lane_en_reg[i] && lane_d[i].locked
                             && (lane_d[i].err_cnt <= thr_reg); // see RULE_05
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            start_prev_reg <= 1'b0;
            running_reg <= 1'b0;
            for (int i = 0; i < LANES; i++)
            begin
                lane_q[i] <= '0;
            end
        end
        else
        begin
            start_prev_reg <= start_prev_next;
            running_reg <= running_next;
            for (int i = 0; i < LANES; i++)
            begin
                lane_q[i] <= lane_d[i];
            end
        end
    end

    // ==========================================================
    // Short transport layer check
    logic tpl_en;
    logic tpl_clear;
    logic [3:0] tpl_sel;
    logic [SAMPLE_W-1:0] tpl_word;
    logic tpl_broken;
    logic tpl_set;

    assign tpl_en = tpl_ctrl_reg[TPL_EN_BIT];
    assign tpl_clear = tpl_ctrl_reg[TPL_RESET_BIT];
    assign tpl_sel = tpl_ctrl_reg[TPL_SEL_LSB +: 4];
    assign tpl_word = tpl_frame.words[int'(tpl_sel)*SAMPLE_W +: SAMPLE_W]; // see RULE_14
    // The hardware in these lane counts cannot check, so it reports failure
    assign tpl_broken = (link_lane_count == LINK_L3) || (link_lane_count == LINK_L6);

    always_comb
    begin
        tpl_set = tpl_en && tpl_frame.valid
                  && (tpl_broken || (tpl_word != exp_reg)); // see RULE_15 RULE_17 RULE_23
        tpl_fail_next = tpl_fail_reg;
        if (tpl_set)
        begin
            tpl_fail_next = 1'b1; // see RULE_17
        end
        else if (tpl_clear)
        begin
            tpl_fail_next = 1'b0; // see RULE_16
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            tpl_fail_reg <= 1'b0;
        end
        else
        begin
            tpl_fail_reg <= tpl_fail_next;
        end
    end

endmodule

// ---- verif/tx_pattern_model.sv ----
`timescale 1ns/100ps
// ==========================================================
// Transmitter sending test patterns
module tx_pattern_model
    import test_check_pkg::*;
(
    input wire logic clk, // Clock
    input wire logic [1:0] pat_sel, // Sequence to send
    input wire logic [7:0] err_mask, // Lanes that get one flipped bit
    input wire logic [15:0] word_base, // Word n carries base plus n
    output logic [63:0] lane_data, // Lane bits, first bit at the top
    output tpl_frame_s tpl_frame // Short transport frame
);
    logic [PRBS_W-1:0] lfsr [8];
    logic nb;
    initial
    begin
        for (int i = 0; i < 8; i++)
            lfsr[i] = PRBS_W'(i + 1);
    end
    // Sends from time zero, before any setup
    always @(posedge clk)
    begin
        for (int i = 0; i < 8; i++)
            for (int j = 7; j >= 0; j--)
            begin
                case (pat_sel)
                    PAT_PRBS15: nb = lfsr[i][TAP15_A] ^ lfsr[i][TAP15_B];
                    PAT_PRBS31: nb = lfsr[i][TAP31_A] ^ lfsr[i][TAP31_B];
                    default: nb = lfsr[i][TAP7_A] ^ lfsr[i][TAP7_B];
                endcase
                lfsr[i] = {lfsr[i][PRBS_W-2:0], nb};
                lane_data[i*8+j] <= nb ^ (j == 0 && err_mask[i]);
            end
    end
    // Unique words per frame; short pattern always on
    always_comb
    begin
        tpl_frame.valid = 1'b1;
        for (int n = 0; n < SAMPLE_WORDS; n++)
            tpl_frame.words[n*SAMPLE_W +: SAMPLE_W] = word_base + 16'(n);
    end
endmodule

// ---- verif/serdes_prbs_and_tpl_checker_asserts.sv ----
`timescale 1ns/100ps
// ==========================================================
// Bus timing and shadowed transport check state
module serdes_prbs_and_tpl_checker_asserts
    import test_check_pkg::*;
(
    input wire logic clk, // Clock
    input wire logic reset, // Async reset
    input wire logic [ADDR_W-1:0] avs_address, // Byte address
    input wire logic avs_read, // Read
    input wire logic avs_write, // Write
    input wire logic [3:0] avs_byteenable, // Byte lanes
    input wire logic [31:0] avs_writedata, // Write data
    input wire logic [31:0] avs_readdata, // Read data
    input wire logic avs_waitrequest, // Stall
    input wire tpl_frame_s tpl_frame, // Frame words
    input wire logic [3:0] link_lane_count // Lane count
);
    logic [11:0] idx;
    logic done_wr, mapped, hit, fail_reg, fail_next;
    logic [7:0] en_reg, en_next, tctl_reg, tctl_next;
    logic [15:0] exp_reg, exp_next, word;
    assign idx = avs_address[ADDR_W-1:IDX_LSB];
    assign done_wr = avs_write && !avs_waitrequest && avs_byteenable[0];
    assign word = tpl_frame.words[tctl_reg[7:4]*SAMPLE_W +: SAMPLE_W];
    always_comb
    begin
        mapped = idx inside {[IDX_LANE_EN:IDX_PASS], [IDX_TPL_CTRL:IDX_TPL_RES]};
        en_next = (done_wr && idx == IDX_LANE_EN) ? avs_writedata[7:0] : en_reg;
        tctl_next = (done_wr && idx == IDX_TPL_CTRL) ? avs_writedata[7:0] : tctl_reg;
        exp_next = exp_reg;
        if (done_wr && idx == IDX_EXP_LO)
            exp_next[7:0] = avs_writedata[7:0];
        if (done_wr && idx == IDX_EXP_HI)
            exp_next[15:8] = avs_writedata[7:0];
        hit = tpl_frame.valid && tctl_reg[TPL_EN_BIT]
            && (word != exp_reg || link_lane_count inside {LINK_L3, LINK_L6});
        // A set in the same cycle as the clear wins
        fail_next = hit || (fail_reg && !tctl_reg[TPL_RESET_BIT]);
    end
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            en_reg <= REG8_RESET;
            tctl_reg <= REG8_RESET;
            exp_reg <= EXP_RESET;
            fail_reg <= 1'b0;
        end
        else
        begin
            en_reg <= en_next;
            tctl_reg <= tctl_next;
            exp_reg <= exp_next;
            fail_reg <= fail_next;
        end
    end
    // ==========================================================
    // Properties
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    sequence s_take;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_rd;
        avs_read && !avs_waitrequest;
    endsequence
    property p_answer; s_take |=> !avs_waitrequest; endproperty
    property p_wait_once; !avs_waitrequest |=> avs_waitrequest; endproperty
    property p_wait_cause; $fell(avs_waitrequest) |-> $past(avs_read || avs_write); endproperty
    property p_unmapped; s_rd ##0 !mapped |-> avs_readdata == 32'h00000000; endproperty
    property p_upper; s_rd |-> avs_readdata[31:8] == 24'h000000; endproperty
    property p_lane_en; s_rd ##0 idx == IDX_LANE_EN |-> avs_readdata[7:0] == en_reg; endproperty
    property p_exp; s_rd ##0 idx == IDX_EXP_HI |-> avs_readdata[7:0] == exp_reg[15:8]; endproperty
    property p_tctl; s_rd ##0 idx == IDX_TPL_CTRL |-> avs_readdata[7:0] == tctl_reg; endproperty
    property p_fail;
        s_rd ##0 (idx == IDX_TPL_RES && $stable(fail_reg)) |-> avs_readdata[RES_FAIL_BIT] == fail_reg;
    endproperty
    a_answer: assert property (p_answer) else $error("late answer");
    a_wait_once: assert property (p_wait_once) else $error("long answer");
    a_wait_cause: assert property (p_wait_cause) else $error("answer unasked");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read");
    a_upper: assert property (p_upper) else $error("upper bits set");
    a_lane_en: assert property (p_lane_en) else $error("lane enable read");
    a_exp: assert property (p_exp) else $error("expected sample read");
    a_tctl: assert property (p_tctl) else $error("transport control read");
    a_fail: assert property (p_fail) else $error("fail flag wrong");
endmodule
bind serdes_prbs_and_tpl_checker serdes_prbs_and_tpl_checker_asserts i_asserts (
    .clk, .reset, .avs_address, .avs_read, .avs_write, .avs_byteenable, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .tpl_frame, .link_lane_count);

// ---- verif/testbench.sv ----
`timescale 1ns/100ps
module testbench
    import test_check_pkg::*;
;
    logic clk, reset, avs_read, avs_write, avs_waitrequest, link_one_converter;
    logic [ADDR_W-1:0] avs_address;
    logic [3:0] avs_byteenable, link_lane_count;
    logic [31:0] avs_writedata, avs_readdata;
    logic [63:0] lane_data;
    tpl_frame_s tpl_frame;
    logic [1:0] pat_sel;
    logic [7:0] err_mask;
    logic [15:0] word_base;
    int err_count, cmp_count;
    serdes_prbs_and_tpl_checker i_serdes_prbs_and_tpl_checker (.clk, .reset, .avs_address,
        .avs_read, .avs_write, .avs_byteenable, .avs_writedata, .avs_readdata,
        .avs_waitrequest, .lane_data, .tpl_frame, .link_lane_count, .link_one_converter);
    tx_pattern_model i_tx_pattern_model (.clk, .pat_sel, .err_mask, .word_base, .lane_data,
        .tpl_frame);
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // ==========================================================
    // Bus access and comparison
    task automatic bus(input logic wr, input logic [11:0] idx, input logic [7:0] wd,
                       output logic [7:0] q);
        @(posedge clk);
        avs_read <= !wr;
        avs_write <= wr;
        avs_address <= {idx, 2'b00};
        avs_writedata <= {24'h000000, wd};
        do
            @(posedge clk);
        while (avs_waitrequest !== 1'b0);
        q = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] idx, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, idx, d, q);
    endtask
    task automatic check(input logic [11:0] idx, input logic [7:0] e, input logic [7:0] m);
        logic [7:0] q;
        bus(1'b0, idx, 8'h00, q);
        cmp_count++;
        if ((q & m) !== (e & m))
        begin
            err_count++;
            $display("unexpected at %0t: reg %h got %h exp %h", $time, idx, q, e);
        end
    endtask
    task automatic inject(input logic [7:0] m, input int n);
        repeat (n)
        begin
            @(posedge clk);
            err_mask <= m;
            @(posedge clk);
            err_mask <= 8'h00;
        end
        repeat (4) @(posedge clk);
    endtask
    // ==========================================================
    // Lane pattern test for one sequence
    task automatic prbs_run(input logic [1:0] p);
        wr(IDX_LANE_EN, 8'h00); // Drops the old lock
        pat_sel <= p;
        wr(IDX_PAT_CTRL, {4'h0, p, 2'b00});
        wr(IDX_LANE_EN, 8'h05);
        wr(IDX_PAT_CTRL, {4'h0, p, 2'b01});
        wr(IDX_PAT_CTRL, {4'h0, p, 2'b00});
        wr(IDX_THR_LO, 8'h02);
        wr(IDX_THR_MID, 8'h00);
        wr(IDX_THR_HI, 8'h00);
        repeat (40) @(posedge clk);
        wr(IDX_PAT_CTRL, {4'h0, p, 2'b10});
        wr(IDX_PAT_CTRL, {4'h0, p, 2'b10});
        inject(8'h04, 3);
        inject(8'h01, 2);
        wr(IDX_PAT_CTRL, {4'h0, p, 2'b00});
        inject(8'h04, 4);
        check(IDX_PASS, 8'h01, 8'hFF);
        wr(IDX_PAT_CTRL, {4'h2, p, 2'b00});
        check(IDX_CNT_LO, 8'h03, 8'hFF);
        check(IDX_CNT_MID, 8'h00, 8'hFF);
        check(IDX_CNT_HI, 8'h00, 8'hFF);
        wr(IDX_PAT_CTRL, {4'h0, p, 2'b00});
        check(IDX_CNT_LO, 8'h02, 8'hFF);
        wr(IDX_PAT_CTRL, {4'h0, p, 2'b01});
        wr(IDX_PAT_CTRL, {4'h0, p, 2'b00});
        check(IDX_CNT_LO, 8'h00, 8'hFF);
        $display("test prbs pattern %0d done", p);
    endtask
    // ==========================================================
    // Transport check for one word selection
    task automatic tpl_case(input logic [3:0] l, input logic one, input logic [3:0] s,
                            input logic ok, input logic en, input logic f);
        logic [15:0] ex;
        logic [2:0] id;
        ex = word_base + 16'(s) + 16'(!ok);
        if (one)
            id = {s[0], s[1], 1'b0};
        else if (l == LINK_L8)
            id = {1'b0, s[1], s[0]};
        else
            id = {2'b00, s[0]};
        link_lane_count <= l;
        link_one_converter <= one;
        wr(IDX_EXP_LO, ex[7:0]);
        wr(IDX_EXP_HI, ex[15:8]);
        wr(IDX_TPL_CTRL, {s, 3'b000, en});
        wr(IDX_TPL_CTRL, {s, 3'b001, en});
        wr(IDX_TPL_CTRL, {s, 3'b000, en});
        repeat (20) @(posedge clk);
        wr(IDX_TPL_CTRL, {s, 4'h0});
        repeat (2) @(posedge clk);
        check(IDX_TPL_RES, {1'b0, id, 3'b000, f}, l inside {LINK_L3, LINK_L6} ? 8'h01 : 8'h71);
        $display("test transport lanes %0d word %0d done", l, s);
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        reset = 1'b1;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = '0;
        avs_writedata = '0;
        avs_byteenable = 4'hF;
        link_lane_count = LINK_L8;
        link_one_converter = 1'b0;
        pat_sel = PAT_PRBS7;
        err_mask = 8'h00;
        word_base = 16'h1A30;
        err_count = 0;
        cmp_count = 0;
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        check(IDX_PAT_CTRL, REG8_RESET, 8'hFF);
        check(IDX_PASS, 8'h00, 8'hFF);
        check(12'h320, 8'h00, 8'hFF);
        wr(IDX_PASS, 8'hFF);
        check(IDX_PASS, 8'h00, 8'hFF);
        $display("test reset values done");
        for (int p = 0; p < 3; p++)
            prbs_run(2'(p));
        tpl_case(LINK_L8, 1'b0, 4'h5, 1'b1, 1'b1, 1'b0);
        tpl_case(LINK_L8, 1'b0, 4'h6, 1'b0, 1'b1, 1'b1);
        check(IDX_TPL_RES, 8'h01, 8'h01);
        tpl_case(LINK_L8, 1'b0, 4'h2, 1'b0, 1'b0, 1'b0);
        tpl_case(4'h4, 1'b0, 4'h7, 1'b1, 1'b1, 1'b0);
        tpl_case(4'h2, 1'b0, 4'hC, 1'b1, 1'b1, 1'b0);
        tpl_case(LINK_L3, 1'b0, 4'h0, 1'b1, 1'b1, 1'b1);
        tpl_case(LINK_L6, 1'b0, 4'h1, 1'b1, 1'b1, 1'b1);
        tpl_case(LINK_L8, 1'b1, 4'hD, 1'b1, 1'b1, 1'b0);
        finish_test();
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        err_count++;
        $display("unexpected at %0t: timeout got %h exp %h", $time, 1'b0, 1'b1);
        finish_test();
    end
endmodule
